// [hw/pmu_regs.svh]
// register offsets, field positions, reset values and timing counts of the power unit
`ifndef PMU_REGS_SVH
`define PMU_REGS_SVH
`define PMU_REG_REV 8'h00
`define PMU_REG_VSA 8'h01
`define PMU_REG_VSB 8'h02
`define PMU_REG_ENH 8'h03
`define PMU_REG_OPT 8'h04
`define PMU_REG_GPF 8'h05
`define PMU_VSA_RST 3'h5
`define PMU_VSB_RST 4'h1
`define PMU_VLIN_RST 4'h0
`define PMU_EN_LSB 5
`define PMU_EN_ALL_BIT 4
`define PMU_FORCE_BIT 0
`define PMU_MASK_LSB 1
`define PMU_TSD_BIT 0
`define PMU_CLKSEL_LSB 5
`define PMU_GP_DRV_BIT 0
`define PMU_GP_OE_BIT 1
`define PMU_LINK_ADDR 7'h2A
`define PMU_CLK_HZ 250000000
`define PMU_LINK_HZ 100000
`define PMU_RELEASE_US 1000
`define PMU_GAP_UNIT_US 1000
`define PMU_RELEASE_CYC (`PMU_CLK_HZ / 1000000 * `PMU_RELEASE_US)
`define PMU_MS_CYC (`PMU_CLK_HZ / 1000000 * `PMU_GAP_UNIT_US)
`define PMU_QUARTER_CYC (`PMU_CLK_HZ / `PMU_LINK_HZ / 4)
`define PMU_H_CTRL 8'h00
`define PMU_H_STAT 8'h04
`define PMU_H_SEQ 8'h08
`define PMU_H_SHADOW 8'h10
`define PMU_AXI_OKAY 2'h0
`define PMU_AXI_SLVERR 2'h2
`endif

// [hw/pmu_pkg.sv]
// types shared by both ends of the power unit link
package pmu_pkg;
  typedef enum logic [4:0] {
    D_IDLE = 5'h01, D_RX = 5'h02, D_ACK = 5'h04, D_TX = 5'h08, D_MACK = 5'h10
  } pmu_dev_st_type;
  typedef enum logic [2:0] {H_IDLE = 3'h1, H_XFER = 3'h2, H_GAP = 3'h4} pmu_host_st_type;
  typedef enum logic [3:0] {K_START = 4'h1, K_BYTE = 4'h2, K_STOP = 4'h4, K_END = 4'h8} pmu_step_type;
  typedef struct packed {
    pmu_dev_st_type st;
    logic [5:0] pin_s0;
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic [5:0] pin_f;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [1:0] bidx;
    logic rw;
    logic ack_on;
    logic drv;
    logic [7:0] ptr;
    logic [2:0] vsa;
    logic [3:0] vsb;
    logic [3:0] vlin;
    logic [2:0] en;
    logic en_all;
    logic force_on;
    logic [2:0] mask;
    logic thermal_trip_flag;
    logic [1:0] clksel;
    logic gp_oe;
    logic gp_drv;
    logic [19:0] rel_cnt;
    logic rel_on;
  } pmu_dev_state_type;
  typedef struct packed {
    pmu_host_st_type st;
    logic [11:0] qcnt;
    logic [1:0] ph;
    logic [3:0] si;
    logic [3:0] bc;
    logic rd;
    logic [7:0] xaddr;
    logic [7:0] xdata;
    logic [7:0] rbyte;
    logic nack;
    logic scl;
    logic sda_oe;
    logic gap_after;
    logic [5:0][7:0] shadow;
    logic [5:0] pend;
    logic auto_upd;
    logic [2:0] sel;
    logic rd_req;
    logic seq_act;
    logic seq_off;
    logic [1:0] slot;
    logic [5:0] slots;
    logic [15:0] gap;
    logic [19:0] ms_cnt;
    logic [15:0] gap_cnt;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } pmu_host_state_type;
endpackage

// [hw/pmu_link_if.sv]
// serial link between the controller and the power unit, open-drain data line
`timescale 1ns/1ps
interface pmu_link_if;
  logic scl;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic sda;
  assign sda = ~((sda_host_oe & ~sda_host_out) | (sda_dev_oe & ~sda_dev_out));
  modport host (output scl, output sda_host_out, output sda_host_oe, input sda);
  modport dev (input scl, input sda, output sda_dev_out, output sda_dev_oe);
endinterface

// [hw/pmu_dev.sv]
// power unit end: register bank reached over the serial link
`timescale 1ns/1ps
`include "pmu_regs.svh"
module pmu_dev #(
  parameter int REL_CYC = `PMU_RELEASE_CYC,
  parameter logic [2:0] MAJOR_REV = 3'h1,  // arbitrary value
  parameter logic [2:0] MINOR_REV = 3'h0,  // arbitrary value
  parameter logic [1:0] DEV_OPTION = 2'h0  // arbitrary value
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // serial link
  pmu_link_if.dev link,
  // regulator status
  input wire logic [2:0] healthy_in,
  input wire logic thermal_trip_in,
  // regulator control
  output logic [2:0] reg_on_out,
  output logic [2:0] buck_a_voltage_code_out,
  output logic [3:0] buck_b_voltage_code_out,
  output logic [3:0] linear_reg_voltage_code_out,
  output logic ext_clock_low_freq_sel_out,
  output logic ext_clock_high_freq_sel_out,
  output logic sensor_shutdown_release_pin_out,
  // general purpose pin
  output logic gp_pin_out,
  output logic gp_pin_oe_out
);

  // ***************************************************************
  // state
  // ***************************************************************
  localparam pmu_pkg::pmu_dev_state_type DEV_RST = '{
    st: pmu_pkg::D_IDLE,
    pin_s0: 6'h03,
    pin_s1: 6'h03,
    pin_s2: 6'h03,
    pin_f: 6'h03,
    vsa: `PMU_VSA_RST,
    vsb: `PMU_VSB_RST,
    vlin: `PMU_VLIN_RST,
    default: '0
  };

  pmu_pkg::pmu_dev_state_type q;
  pmu_pkg::pmu_dev_state_type n;
  logic [5:0] f;
  logic rise;
  logic fall;
  logic wr;
  logic [7:0] b;
  logic [2:0] on;
  logic [2:0] pg;
  logic tgt;
  logic [7:0] rd_byte;

  // ***************************************************************
  // register read decode
  // ***************************************************************
  function automatic logic [7:0] rd_byte_f(input pmu_pkg::pmu_dev_state_type s,
                                           input logic [2:0] good);
    logic [7:0] r;
    r = 8'h00;
    if (s.ptr == `PMU_REG_REV) begin
      r = {MAJOR_REV, MINOR_REV, DEV_OPTION};
    end else if (s.ptr == `PMU_REG_VSA) begin
      r = {5'h00, s.vsa};
    end else if (s.ptr == `PMU_REG_VSB) begin
      r = {s.vsb, s.vlin};
    end else if (s.ptr == `PMU_REG_ENH) begin
      r = {s.en, s.en_all, good, s.force_on};
    end else if (s.ptr == `PMU_REG_OPT) begin
      r = {1'b0, s.clksel, 1'b0, s.mask, s.thermal_trip_flag};
    end else if (s.ptr == `PMU_REG_GPF) begin
      r = {6'h00, s.gp_oe, s.gp_drv};
    end
    return r;
  endfunction

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    n = q;
    wr = 1'b0;
    // pins are taken only once the second and third stages agree
    f = (q.pin_s1 & q.pin_s2) | (q.pin_f & (q.pin_s1 ^ q.pin_s2));
    n.pin_s0 = {thermal_trip_in, healthy_in, link.sda, link.scl};
    n.pin_s1 = q.pin_s0;
    n.pin_s2 = q.pin_s1;
    n.pin_f = f;
    rise = f[0] & ~q.pin_f[0];
    fall = ~f[0] & q.pin_f[0];
    b = {q.sh[6:0], f[1]};
    on = (q.en | {3{q.en_all}}) & {3{~q.thermal_trip_flag}};
    pg = q.pin_f[4:2] & on;
    rd_byte = rd_byte_f(q, pg);
    if (q.pin_f[0] & f[0] & (q.pin_f[1] ^ f[1])) begin
      // data moves while clock high: start or stop
      n.st = f[1] ? pmu_pkg::D_IDLE : pmu_pkg::D_RX;
      n.cnt = 3'h0;
      n.bidx = 2'h0;
      n.drv = 1'b0;
      n.ack_on = 1'b0;
    end else begin
      case (q.st)
        pmu_pkg::D_RX: begin
          if (rise) begin
            n.sh = b;
            n.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7) begin
              n.st = pmu_pkg::D_ACK;
              if (q.bidx == 2'h0) begin
                n.rw = f[1];
                if (q.sh[6:0] != `PMU_LINK_ADDR) begin
                  n.st = pmu_pkg::D_IDLE;
                end
              end else if (q.bidx == 2'h1) begin
                n.ptr = b;
              end else begin
                wr = 1'b1;
                n.ptr = q.ptr + 8'h01;
              end
              if (q.bidx != 2'h2) begin
                n.bidx = q.bidx + 2'h1;
              end
            end
          end
        end
        pmu_pkg::D_ACK: begin
          if (fall) begin
            n.ack_on = ~q.ack_on;
            n.drv = ~q.ack_on;
            n.cnt = 3'h0;
            if (q.ack_on & q.rw) begin
              n.st = pmu_pkg::D_TX;
              n.sh = rd_byte;
              n.drv = ~rd_byte[7];
            end else if (q.ack_on) begin
              n.st = pmu_pkg::D_RX;
            end
          end
        end
        pmu_pkg::D_TX: begin
          if (rise) begin
            n.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7) begin
              n.st = pmu_pkg::D_MACK;
            end
          end else if (fall) begin
            n.drv = ~q.sh[6];
            n.sh = {q.sh[6:0], 1'b0};
          end
        end
        pmu_pkg::D_MACK: begin
          if (fall) begin
            n.drv = 1'b0;
          end else if (rise) begin
            if (f[1]) begin
              n.st = pmu_pkg::D_IDLE;
            end else begin
              n.st = pmu_pkg::D_ACK;
              n.ack_on = 1'b1;
              n.ptr = q.ptr + 8'h01;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // register writes; the revision word has no write path
    if (wr) begin
      if (q.ptr == `PMU_REG_VSA) begin
        n.vsa = b[2:0];
      end else if (q.ptr == `PMU_REG_VSB) begin
        n.vsb = b[7:4];
        n.vlin = b[3:0];
      end else if (q.ptr == `PMU_REG_ENH) begin
        n.en = b[7:`PMU_EN_LSB];
        n.en_all = b[`PMU_EN_ALL_BIT];
        n.force_on = b[`PMU_FORCE_BIT];
      end else if (q.ptr == `PMU_REG_OPT) begin
        n.clksel = b[6:`PMU_CLKSEL_LSB];
        n.mask = b[3:`PMU_MASK_LSB];
      end else if (q.ptr == `PMU_REG_GPF) begin
        n.gp_oe = b[`PMU_GP_OE_BIT];
        n.gp_drv = b[`PMU_GP_DRV_BIT];
      end
    end
    // trip input wins over a clearing write
    n.thermal_trip_flag = f[5] | ((wr && q.ptr == `PMU_REG_OPT) ? b[`PMU_TSD_BIT] : q.thermal_trip_flag);
    // release follows forced, unmasked health after a fixed wait
    tgt = q.force_on & (&(pg | q.mask));
    n.rel_cnt = (tgt & ~q.rel_on) ? q.rel_cnt + 20'h00001 : 20'h00000;
    n.rel_on = tgt & (q.rel_on | (q.rel_cnt == 20'(REL_CYC - 1)));
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= DEV_RST;
    end else begin
      q <= n;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe = q.drv;
  assign reg_on_out = (q.en | {3{q.en_all}}) & {3{~q.thermal_trip_flag}};
  assign buck_a_voltage_code_out = q.vsa;
  assign buck_b_voltage_code_out = q.vsb;
  assign linear_reg_voltage_code_out = q.vlin;
  assign ext_clock_low_freq_sel_out = q.clksel[1];
  assign ext_clock_high_freq_sel_out = q.clksel[0];
  assign sensor_shutdown_release_pin_out = q.rel_on;
  assign gp_pin_out = q.gp_drv;
  assign gp_pin_oe_out = q.gp_oe;

endmodule // pmu_dev

// [hw/pmu_host.sv]
// controller end: software registers, link master and regulator sequencer
`timescale 1ns/1ps
`include "pmu_regs.svh"
module pmu_host #(
  parameter int MS_CYC = `PMU_MS_CYC,
  parameter int QUARTER_CYC = `PMU_QUARTER_CYC
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // serial link
  pmu_link_if.host link,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);

  localparam pmu_pkg::pmu_host_state_type HOST_RST = '{st: pmu_pkg::H_IDLE, scl: 1'b1,
                                                      default: '0};
  pmu_pkg::pmu_host_state_type q;
  pmu_pkg::pmu_host_state_type n;
  pmu_pkg::pmu_step_type kind;
  logic [7:0] bt;
  logic tick;
  logic rdb;
  logic go;
  logic go_rd;
  logic go_gap;
  logic [2:0] go_idx;
  logic [2:0] pidx;
  logic [1:0] sidx;
  logic [1:0] r;
  logic aw_ok;
  logic ar_ok;
  logic [7:0] wa;
  logic [7:0] ra;

  // write: start, addr, ptr, data, stop; read: start, addr, ptr, stop, start, addr, data, stop
  function automatic pmu_pkg::pmu_step_type step_kind(input logic rd, input logic [3:0] si);
    pmu_pkg::pmu_step_type k;
    k = pmu_pkg::K_BYTE;
    if (si == 4'h0 || (rd && si == 4'h4)) begin
      k = pmu_pkg::K_START;
    end else if ((!rd && si == 4'h4) || (rd && (si == 4'h3 || si == 4'h7))) begin
      k = pmu_pkg::K_STOP;
    end else if ((!rd && si > 4'h4) || si > 4'h7) begin
      k = pmu_pkg::K_END;
    end
    return k;
  endfunction

  always_comb begin
    n = q;
    go = 1'b0;
    go_rd = 1'b0;
    go_gap = 1'b0;
    go_idx = 3'h0;
    pidx = 3'h0;
    r = 2'h3;
    tick = (q.qcnt == 12'(QUARTER_CYC - 1));
    n.qcnt = tick ? 12'h000 : q.qcnt + 12'h001;
    kind = step_kind(q.rd, q.si);
    rdb = q.rd & (q.si == 4'h6);
    bt = rdb ? 8'hFF : (q.si == 4'h1 || q.si == 4'h5) ? {`PMU_LINK_ADDR, q.si == 4'h5} :
         (q.si == 4'h2) ? q.xaddr : q.xdata;
    sidx = q.seq_off ? 2'h2 - q.slot : q.slot;
    for (int i = 5; i >= 0; i--) begin
      if (q.pend[i]) begin
        pidx = 3'(i);
      end
    end
    case (q.st)
      pmu_pkg::H_IDLE: begin
        if (q.pend != 6'h00) begin
          go = 1'b1;
          go_idx = pidx;
          n.pend[pidx] = 1'b0;
        end else if (q.seq_act) begin
          if (q.slot == 2'h3) begin
            n.seq_act = 1'b0;
          end else begin
            r = q.slots[2 * sidx +: 2];
            if (r != 2'h3) begin
              n.shadow[3][`PMU_EN_LSB + r] = ~q.seq_off;
            end
            n.slot = q.slot + 2'h1;
            if (q.gap != 16'h0000 || q.slot == 2'h2) begin
              go = 1'b1;  // zero gap folds slots into one write
              go_idx = 3'h3;
              go_gap = (q.slot != 2'h2);
            end
          end
        end else if (q.rd_req) begin
          go = 1'b1;
          go_rd = 1'b1;
          go_idx = q.sel;
          n.rd_req = 1'b0;
        end
      end
      pmu_pkg::H_XFER: begin
        if (tick) begin
          n.ph = q.ph + 2'h1;
          if (kind == pmu_pkg::K_END) begin
            n.st = q.gap_after ? pmu_pkg::H_GAP : pmu_pkg::H_IDLE;
            n.ms_cnt = 20'h00000;
            n.gap_cnt = 16'h0000;
            if (q.rd && q.xaddr < 8'h06) begin
              n.shadow[q.xaddr[2:0]] = q.rbyte;
              if (q.xaddr == `PMU_REG_OPT) begin
                n.shadow[4][`PMU_TSD_BIT] = 1'b0;
              end
            end
          end else if (kind == pmu_pkg::K_START) begin
            n.scl = (q.ph == 2'h0) ? 1'b1 : (q.ph == 2'h2) ? 1'b0 : q.scl;
            n.sda_oe = (q.ph != 2'h0);
            n.si = (q.ph == 2'h3) ? q.si + 4'h1 : q.si;
          end else if (kind == pmu_pkg::K_STOP) begin
            n.scl = (q.ph != 2'h0);
            n.sda_oe = (q.ph < 2'h2);
            n.si = (q.ph == 2'h3) ? q.si + 4'h1 : q.si;
          end else begin
            if (q.ph == 2'h0) begin
              n.sda_oe = (q.bc < 4'h8) & ~bt[3'(4'h7 - q.bc)];
            end else if (q.ph == 2'h1) begin
              n.scl = 1'b1;
            end else if (q.ph == 2'h2) begin
              if (q.bc == 4'h8 && !rdb && link.sda) begin
                n.nack = 1'b1;
              end
              if (rdb && q.bc < 4'h8) begin
                n.rbyte = {q.rbyte[6:0], link.sda};
              end
            end else begin
              n.scl = 1'b0;
              // free the line for the ack as the clock falls, before the device pulls it
              n.sda_oe = q.sda_oe & (q.bc != 4'h7);
              n.bc = (q.bc == 4'h8) ? 4'h0 : q.bc + 4'h1;
              n.si = (q.bc == 4'h8) ? q.si + 4'h1 : q.si;
            end
          end
        end
      end
      pmu_pkg::H_GAP: begin
        if (q.gap_cnt == q.gap) begin
          n.st = pmu_pkg::H_IDLE;
        end else if (q.ms_cnt == 20'(MS_CYC - 1)) begin
          n.ms_cnt = 20'h00000;
          n.gap_cnt = q.gap_cnt + 16'h0001;
        end else begin
          n.ms_cnt = q.ms_cnt + 20'h00001;
        end
      end
      default: begin
        n.st = pmu_pkg::H_IDLE;
      end
    endcase
    if (go) begin
      n.st = pmu_pkg::H_XFER;
      n.rd = go_rd;
      n.gap_after = go_gap;
      n.xaddr = {5'h00, go_idx};
      n.xdata = n.shadow[go_idx];
      n.si = 4'h0;
      n.bc = 4'h0;
      n.ph = 2'h0;
      n.qcnt = 12'h000;
      n.nack = 1'b0;
    end
    // software writes come last so their flags win
    aw_ok = s_axi_awvalid_in & s_axi_wvalid_in & ~q.bvalid;
    wa = s_axi_awaddr_in;
    if (aw_ok) begin
      n.bvalid = 1'b1;
      n.bresp = `PMU_AXI_OKAY;
      if (wa == `PMU_H_CTRL) begin
        n.auto_upd = s_axi_wdata_in[0];
        n.sel = s_axi_wdata_in[10:8];
        if (s_axi_wdata_in[1] && s_axi_wdata_in[10:8] < 3'h6) begin
          n.pend[s_axi_wdata_in[10:8]] = 1'b1;
        end
        n.rd_req = n.rd_req | s_axi_wdata_in[2];
        if ((s_axi_wdata_in[3] | s_axi_wdata_in[4]) && !q.seq_act) begin
          n.seq_act = 1'b1;
          n.seq_off = s_axi_wdata_in[4];
          n.slot = 2'h0;
          for (int k = 0; k < 3; k++) begin
            if (s_axi_wdata_in[3] && q.slots[1:0] != 2'(k) && q.slots[3:2] != 2'(k)
                && q.slots[5:4] != 2'(k)) begin
              n.shadow[4][`PMU_MASK_LSB + k] = 1'b1;
              n.pend[4] = 1'b1;
            end
          end
        end
      end else if (wa == `PMU_H_SEQ) begin
        n.slots = s_axi_wdata_in[5:0];
        n.gap = s_axi_wdata_in[31:16];
      end else if (wa >= `PMU_H_SHADOW && wa < 8'h28 && wa[1:0] == 2'h0) begin
        if (s_axi_wstrb_in[0]) begin
          n.shadow[3'(wa[4:2] - 3'h4)] = s_axi_wdata_in[7:0];
          n.pend[3'(wa[4:2] - 3'h4)] = n.pend[3'(wa[4:2] - 3'h4)] | q.auto_upd;
        end
      end else begin
        n.bresp = `PMU_AXI_SLVERR;
      end
    end else if (q.bvalid && s_axi_bready_in) begin
      n.bvalid = 1'b0;
    end
    ar_ok = s_axi_arvalid_in & ~q.rvalid;
    ra = s_axi_araddr_in;
    if (ar_ok) begin
      n.rvalid = 1'b1;
      n.rresp = `PMU_AXI_OKAY;
      n.rdata = 32'h00000000;
      if (ra == `PMU_H_CTRL) begin
        n.rdata = {21'h000000, q.sel, 7'h00, q.auto_upd};
      end else if (ra == `PMU_H_STAT) begin
        n.rdata = {16'h0000, q.rbyte, 6'h00, q.nack,
                   (q.st != pmu_pkg::H_IDLE) | (q.pend != 6'h00) | q.seq_act | q.rd_req};
      end else if (ra == `PMU_H_SEQ) begin
        n.rdata = {q.gap, 10'h000, q.slots};
      end else if (ra >= `PMU_H_SHADOW && ra < 8'h28 && ra[1:0] == 2'h0) begin
        n.rdata = {24'h000000, q.shadow[3'(ra[4:2] - 3'h4)]};
      end else begin
        n.rresp = `PMU_AXI_SLVERR;
      end
    end else if (q.rvalid && s_axi_rready_in) begin
      n.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= HOST_RST;
    end else begin
      q <= n;
    end
  end

  assign link.scl = q.scl;
  assign link.sda_host_out = 1'b0;
  assign link.sda_host_oe = q.sda_oe;
  assign s_axi_awready_out = s_axi_awvalid_in & s_axi_wvalid_in & ~q.bvalid;
  assign s_axi_wready_out = s_axi_awvalid_in & s_axi_wvalid_in & ~q.bvalid;
  assign s_axi_bvalid_out = q.bvalid;
  assign s_axi_bresp_out = q.bresp;
  assign s_axi_arready_out = ~q.rvalid;
  assign s_axi_rvalid_out = q.rvalid;
  assign s_axi_rdata_out = q.rdata;
  assign s_axi_rresp_out = q.rresp;

endmodule // pmu_host

// [tb/pmu_link_asserts.sv]
// link protocol checks for the power unit serial link
`timescale 1ns/1ps
module pmu_link_asserts #(
  parameter int QUARTER = 625
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // link
  input wire logic scl,
  input wire logic sda_host_out,
  input wire logic sda_host_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic sda
);
  localparam int START_MIN = QUARTER - 5;
  localparam int START_MAX = QUARTER + 5;
  localparam int HIGH_MIN = 2 * QUARTER - 2;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [11:0] hi_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) hi_q <= 12'h000;
    else if (!scl) hi_q <= 12'h000;
    else if (hi_q != 12'hFFF) hi_q <= hi_q + 12'h001;
  end
  a_host_open_drain: assert property (sda_host_oe |-> !sda_host_out)
    else $error("host drives data high");
  a_dev_open_drain: assert property (sda_dev_oe |-> !sda_dev_out)
    else $error("device drives data high");
  a_no_contention: assert property (!(sda_host_oe && sda_dev_oe))
    else $error("both ends pull data");
  a_dev_scl_low: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device moved data with clock high");
  a_start_shape: assert property (scl && $fell(sda) |-> ##[START_MIN:START_MAX] !scl)
    else $error("start not followed by clock fall");
  a_stop_idle: assert property (scl && $rose(sda) |-> scl [*8])
    else $error("clock left high level after stop");
  a_data_setup: assert property ($rose(scl) |-> $stable(sda_host_oe) [*8])
    else $error("host moved data with clock high");
  a_scl_high_time: assert property ($fell(scl) |-> hi_q >= 12'(HIGH_MIN))
    else $error("clock high phase too short");
endmodule // pmu_link_asserts

// [tb/pmu_control_register_bank_bench.sv]
// self-checking bench for the power unit controller and register bank
`timescale 1ns/1ps
module pmu_control_register_bank_bench;
  localparam int REL = 50;
  localparam int QTR = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [2:0] healthy = 3'h0;
  logic trip = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rel, lo, hi, gp, gpoe;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, q;
  logic [2:0] reg_on, vsa;
  logic [3:0] vsb, vlin;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int c;
  wire [17:0] outs = {reg_on, vsa, vsb, vlin, lo, hi, gp, gpoe};
  logic [28:0] rows [5] = '{{3'h1, 8'h02, 18'h02100}, {3'h2, 8'h7A, 18'h027A0},
    {3'h4, 8'h4C, 18'h027A8}, {3'h5, 8'h03, 18'h027AB}, {3'h3, 8'hA1, 18'h2A7AB}};
  pmu_link_if pmu_link_if_i ();
  pmu_host #(.MS_CYC(50), .QUARTER_CYC(QTR)) pmu_host_i (.ref_clk_in(clk), .rst_n_in(rst_n),
    .link(pmu_link_if_i), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  pmu_dev #(.REL_CYC(REL)) pmu_dev_i (.ref_clk_in(clk), .rst_n_in(rst_n),
    .link(pmu_link_if_i), .healthy_in(healthy), .thermal_trip_in(trip), .reg_on_out(reg_on),
    .buck_a_voltage_code_out(vsa), .buck_b_voltage_code_out(vsb),
    .linear_reg_voltage_code_out(vlin), .ext_clock_low_freq_sel_out(lo),
    .ext_clock_high_freq_sel_out(hi), .sensor_shutdown_release_pin_out(rel),
    .gp_pin_out(gp), .gp_pin_oe_out(gpoe));
  pmu_link_asserts #(.QUARTER(QTR)) pmu_link_asserts_i (.ref_clk_in(clk), .rst_n_in(rst_n),
    .scl(pmu_link_if_i.scl), .sda_host_out(pmu_link_if_i.sda_host_out),
    .sda_host_oe(pmu_link_if_i.sda_host_oe), .sda_dev_out(pmu_link_if_i.sda_dev_out),
    .sda_dev_oe(pmu_link_if_i.sda_dev_oe), .sda(pmu_link_if_i.sda));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
    n_checks++;
    if (v !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one register-bus transfer, write or read
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    @(posedge clk);
    while (!(wr ? awready && wready : arready)) @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    arvalid <= 1'b0;
    while (!(wr ? bvalid : rvalid)) @(posedge clk);
    q = rdata;
    r = wr ? bresp : rresp;
    bready <= 1'b0;
    rready <= 1'b0;
  endtask
  // poll the busy flag; the last status word stays in q
  task automatic wait_idle;
    q = 32'h1;
    while (q[0]) axi(1'b0, 8'h04, 32'h0);
  endtask
  // shadow write, then wait until the link transfer is over
  task automatic dev_wr(input logic [2:0] n, input logic [7:0] v);
    axi(1'b1, 8'h10 + {3'h0, n, 2'h0}, {24'h0, v});
    while (pmu_link_if_i.scl) @(posedge clk);
    wait_idle();
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    chk("reset outputs", {14'h0, outs}, 32'h05100);
    chk("reset release", {31'h0, rel}, 32'h0);
    rst_n <= 1'b1;
    axi(1'b1, 8'h0C, 32'h0);
    chk("unmapped write", {30'h0, r}, 32'h2);
    axi(1'b0, 8'h0C, 32'h0);
    chk("unmapped read", {q[29:0], r}, 32'h2);
    axi(1'b1, 8'h00, 32'h1);
    for (int i = 0; i < 5; i++) begin
      dev_wr(rows[i][28:26], rows[i][25:18]);
      chk("outputs", {14'h0, outs}, {14'h0, rows[i][17:0]});
      $display("row %0d done", i);
    end
    chk("release unhealthy", {31'h0, rel}, 32'h0);
    healthy <= 3'h1;
    for (c = 0; !rel && c < 1000; c++) @(posedge clk);
    chk("release delay", {31'h0, (c >= REL && c <= REL + 8)}, 32'h1);
    healthy <= 3'h0;
    for (c = 0; rel && c < 1000; c++) @(posedge clk);
    chk("release drop", {31'h0, (c <= 6)}, 32'h1);
    $display("release test done");
    trip <= 1'b1;
    for (c = 0; reg_on !== 3'h0 && c < 1000; c++) @(posedge clk);
    chk("thermal stop", {28'h0, (c <= 6), reg_on}, 32'h8);
    trip <= 1'b0;
    dev_wr(3'h4, 8'h4C);
    chk("thermal clear", {29'h0, reg_on}, 32'h5);
    $display("thermal test done");
    dev_wr(3'h0, 8'hFF);
    axi(1'b1, 8'h00, 32'h00000005);
    wait_idle();
    chk("revision", {24'h0, q[15:8]}, {24'h0, 3'h1, 3'h0, 2'h0});
    $display("revision test done");
    axi(1'b1, 8'h08, 32'h0001000E);
    axi(1'b1, 8'h00, 32'h00000011);
    for (c = 0; reg_on == 3'h5 && c < 20000; c++) @(posedge clk);
    chk("off first step", {29'h0, reg_on}, 32'h4);
    wait_idle();
    chk("off done", {29'h0, reg_on}, 32'h0);
    dev_wr(3'h4, 8'h40);
    axi(1'b1, 8'h00, 32'h00000009);
    for (c = 0; reg_on == 3'h0 && c < 20000; c++) @(posedge clk);
    chk("on first step", {29'h0, reg_on}, 32'h4);
    wait_idle();
    chk("on done", {29'h0, reg_on}, 32'h5);
    axi(1'b1, 8'h00, 32'h00000405);
    wait_idle();
    chk("unused masked", {24'h0, q[15:8]}, 32'h44);
    $display("sequence test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("mid reset outputs", {14'h0, outs}, 32'h05100);
    chk("mid reset release", {31'h0, rel}, 32'h0);
    rst_n <= 1'b1;
    axi(1'b0, 8'h00, 32'h0);
    chk("mid reset ctrl", q, 32'h0);
    $display("reset test done");
    tally_and_finish();
  end
endmodule // pmu_control_register_bank_bench
